// >>> pin_select_pkg.sv
`default_nettype none

package pin_select_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_A_DIRECTION   = 8'h00;
  localparam logic [7:0] ADDR_PORT_A_OUTPUT_DATA = 8'h04;
  localparam logic [7:0] ADDR_PORT_A_PIN_STATE   = 8'h08;
  localparam logic [7:0] ADDR_ALT_PIN_SELECT     = 8'h0C;
  localparam logic [7:0] ADDR_PORT_NINE_CTRL     = 8'h10;
  localparam logic [7:0] ADDR_CH1_TIMER_CFG      = 8'h14;
  localparam logic [7:0] ADDR_CH2_TIMER_CFG      = 8'h18;
  localparam logic [7:0] ADDR_PRESCALER_CFG      = 8'h1C;

  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  localparam logic [31:0] UNDEFINED_READ   = 32'h0000_0000;
  localparam int ALT_CH2_A_BIT             = 0;
  localparam int ALT_CH1_B_BIT             = 1;
  localparam int P9_DIR90_BIT              = 0;
  localparam int P9_DIR91_BIT              = 1;
  localparam int P9_OUT90_BIT              = 2;
  localparam int P9_OUT91_BIT              = 3;
  localparam int P9_EXPANDED_BIT           = 4;
  localparam int P9_LWR_EN_BIT             = 5;
  localparam int P9_CS2_EN_BIT             = 6;
  // Timer config: [3:0] mode, [7:4] A io, [11:8] B io, [13:12] clear select
  localparam int CFG_MODE_LSB              = 0;
  localparam int CFG_IOA_LSB               = 4;
  localparam int CFG_IOB_LSB               = 8;
  localparam int CFG_CCLR_LSB              = 12;
  // Prescaler config: [2:0] ch0, [5:3] ch2
  localparam int PSC_CH0_LSB               = 0;
  localparam int PSC_CH2_LSB               = 3;

  // ----------------------------------------------------------------------
  // Timer encodings
  // ----------------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL       = 4'h0;
  localparam logic [3:0] MODE_PWM1         = 4'h2;
  localparam logic [3:0] MODE_PWM2         = 4'h3;
  localparam logic [1:0] MODE_PHASE_TOP    = 2'h1;
  localparam logic [2:0] PSC_EXT_CLOCK_C   = 3'h7;
  localparam logic [1:0] IO_INPUT_TOP      = 2'h2;
  localparam logic [1:0] CCLR_CH1_SYNC     = 2'h2;
  localparam logic [1:0] CCLR_CH2_SYNC     = 2'h1;

endpackage

`default_nettype wire

// >>> port_pin_function_select.sv
//
// Overview of operation
// - P91 feeds ch2 A capture when selected
// - PWM1 on relocated ch2 A suppresses ch2 B output
// - P90 ch1 B timer functions only when relocation set
// - Expanded mode drives low strobe on P90
// - P90 feeds ch1 B capture when selected
// - Prescaler 111 with relocation set makes P90 clock C input
// - Ch2 phase-count with relocation clear uses clock C
// - Port A is eight bidirectional pins
// - Direction bit one drives, resets to zero
// - Direction register write-only, reads undefined
// - Output data register readable, resets zero
// - Pin-state read mixes data and pin level
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module port_pin_function_select
  import pin_select_pkg::*;
#(
  parameter int PORT_A_WIDTH = 8
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  input  wire logic [PORT_A_WIDTH-1:0] port_a_in,
  output logic [PORT_A_WIDTH-1:0]      port_a_out,
  output logic [PORT_A_WIDTH-1:0]      port_a_oe_n,
  input  wire logic                    pin90_in,
  output logic                         pin90_out,
  output logic                         pin90_oe_n,
  input  wire logic                    pin91_in,
  output logic                         pin91_out,
  output logic                         pin91_oe_n,
  input  wire logic                    low_write_strobe,
  input  wire logic                    chip_select_2,
  input  wire logic                    ch1_b_compare_out,
  input  wire logic                    ch2_a_compare_out,
  input  wire logic                    ch2_b_compare_out,
  output logic                         ch2_b_output_allowed,
  output logic                         ch1_b_capture_compare,
  output logic                         ch1_b_capture_valid,
  output logic                         ch2_a_capture_compare,
  output logic                         ch2_a_capture_valid,
  output logic                         ext_clock_c_input,
  output logic                         ext_clock_c_valid
);

  initial begin
    if (PORT_A_WIDTH != 8) $error("port A is eight pins wide");
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]  port_a_direction;
  logic [7:0]  port_a_output_data;
  logic [1:0]  alt_pin_select_reg;
  logic [6:0]  port_nine_ctrl;
  logic [13:0] ch1_cfg;
  logic [13:0] ch2_cfg;
  logic [5:0]  prescaler_cfg;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire logic wr_en       = psel && penable && pwrite;
  wire logic hit_dir     = (paddr == ADDR_PORT_A_DIRECTION);
  wire logic hit_data    = (paddr == ADDR_PORT_A_OUTPUT_DATA);
  wire logic hit_state   = (paddr == ADDR_PORT_A_PIN_STATE);
  wire logic hit_alt     = (paddr == ADDR_ALT_PIN_SELECT);
  wire logic hit_p9      = (paddr == ADDR_PORT_NINE_CTRL);
  wire logic hit_ch1     = (paddr == ADDR_CH1_TIMER_CFG);
  wire logic hit_ch2     = (paddr == ADDR_CH2_TIMER_CFG);
  wire logic hit_psc     = (paddr == ADDR_PRESCALER_CFG);
  wire logic hit_any     = hit_dir | hit_data | hit_state | hit_alt | hit_p9 | hit_ch1 | hit_ch2 | hit_psc;
  // Pin-state register is read-only, so a write to it errors like a miss
  wire logic bad_access  = !hit_any || (pwrite && hit_state);

  assign pready  = 1'b1;
  assign pslverr = psel && penable && bad_access;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_direction   <= RESET_BYTE;
      port_a_output_data <= RESET_BYTE;
      alt_pin_select_reg <= 2'h0;
      port_nine_ctrl     <= 7'h00;
      ch1_cfg            <= 14'h0000;
      ch2_cfg            <= 14'h0000;
      prescaler_cfg      <= 6'h00;
    end else if (wr_en) begin
      if (hit_dir)  port_a_direction   <= pwdata[7:0];
      if (hit_data) port_a_output_data <= pwdata[7:0];
      if (hit_alt)  alt_pin_select_reg <= pwdata[1:0];
      if (hit_p9)   port_nine_ctrl     <= pwdata[6:0];
      if (hit_ch1)  ch1_cfg            <= pwdata[13:0];
      if (hit_ch2)  ch2_cfg            <= pwdata[13:0];
      if (hit_psc)  prescaler_cfg      <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // Port A general I/O
  // ----------------------------------------------------------------------
  wire logic [7:0] port_a_pin_state = (port_a_direction & port_a_output_data)
                                    | (~port_a_direction & port_a_in);

  assign port_a_out  = port_a_output_data;
  assign port_a_oe_n = ~port_a_direction;

  // Direction has no read path at all; reads return a fixed filler value
  wire logic [31:0] next_prdata =
      hit_dir   ? UNDEFINED_READ :
      hit_data  ? {24'h000000, port_a_output_data} :
      hit_state ? {24'h000000, port_a_pin_state} :
      hit_alt   ? {30'h00000000, alt_pin_select_reg} :
      hit_p9    ? {25'h0000000, port_nine_ctrl} :
      hit_ch1   ? {18'h00000, ch1_cfg} :
      hit_ch2   ? {18'h00000, ch2_cfg} :
      hit_psc   ? {26'h0000000, prescaler_cfg} : 32'h0000_0000;

  assign prdata = (psel && !pwrite) ? next_prdata : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Timer field decode
  // ----------------------------------------------------------------------
  wire logic       ch2_a_relocate_sel  = alt_pin_select_reg[ALT_CH2_A_BIT];
  wire logic       ch1_b_relocate_sel  = alt_pin_select_reg[ALT_CH1_B_BIT];
  wire logic       expanded_mode_en    = port_nine_ctrl[P9_EXPANDED_BIT];
  wire logic       low_write_strobe_en = port_nine_ctrl[P9_LWR_EN_BIT];
  wire logic       chip_select_2_en    = port_nine_ctrl[P9_CS2_EN_BIT];
  wire logic       pin90_direction_bit = port_nine_ctrl[P9_DIR90_BIT];
  wire logic       pin91_direction_bit = port_nine_ctrl[P9_DIR91_BIT];
  wire logic [3:0] ch1_mode = ch1_cfg[CFG_MODE_LSB +: 4];
  wire logic [3:0] ch1_iob  = ch1_cfg[CFG_IOB_LSB +: 4];
  wire logic [1:0] ch1_cclr = ch1_cfg[CFG_CCLR_LSB +: 2];
  wire logic [3:0] ch2_mode = ch2_cfg[CFG_MODE_LSB +: 4];
  wire logic [3:0] ch2_ioa  = ch2_cfg[CFG_IOA_LSB +: 4];
  wire logic [1:0] ch2_cclr = ch2_cfg[CFG_CCLR_LSB +: 2];
  wire logic [2:0] psc_ch0  = prescaler_cfg[PSC_CH0_LSB +: 3];
  wire logic [2:0] psc_ch2  = prescaler_cfg[PSC_CH2_LSB +: 3];

  wire logic ch1_capture_mode = (ch1_mode == MODE_NORMAL) || (ch1_mode[3:2] == MODE_PHASE_TOP);
  wire logic ch2_capture_mode = (ch2_mode == MODE_NORMAL) || (ch2_mode[3:2] == MODE_PHASE_TOP);
  wire logic ch2_phase_count  = (ch2_mode[3:2] == MODE_PHASE_TOP);
  wire logic ch1_compare_out  = ch1_capture_mode && (ch1_iob[3] == 1'b0) && (ch1_iob[1:0] != 2'h0);
  wire logic ch1_pwm2_out     = (ch1_mode == MODE_PWM2) && (ch1_iob[1:0] != 2'h0)
                              && (ch1_cclr != CCLR_CH1_SYNC);
  wire logic ch2_compare_out  = ch2_capture_mode && (ch2_ioa[3] == 1'b0) && (ch2_ioa[1:0] != 2'h0);
  wire logic ch2_pwm1_out     = (ch2_mode == MODE_PWM1) && (ch2_ioa[1:0] != 2'h0);
  wire logic ch2_pwm2_out     = (ch2_mode == MODE_PWM2) && (ch2_ioa[1:0] != 2'h0)
                              && (ch2_cclr != CCLR_CH2_SYNC);

  // ----------------------------------------------------------------------
  // P90: low strobe, relocated ch1 B, clock C
  // ----------------------------------------------------------------------
  wire logic p90_strobe   = expanded_mode_en && low_write_strobe_en;
  wire logic p90_timer_out = ch1_b_relocate_sel && (ch1_compare_out || ch1_pwm2_out);
  wire logic p90_drive    = p90_strobe || p90_timer_out || pin90_direction_bit;

  assign pin90_out  = p90_strobe    ? low_write_strobe :
                      p90_timer_out ? ch1_b_compare_out : port_nine_ctrl[P9_OUT90_BIT];
  assign pin90_oe_n = !p90_drive;

  // Inputs sample the pin even while the strobe drives it
  assign ch1_b_capture_compare = pin90_in;
  assign ch1_b_capture_valid   = ch1_b_relocate_sel && ch1_capture_mode
                               && (ch1_iob[3:2] == IO_INPUT_TOP);
  assign ext_clock_c_input     = pin90_in;
  assign ext_clock_c_valid     = (ch1_b_relocate_sel && ((psc_ch0 == PSC_EXT_CLOCK_C)
                               || (psc_ch2 == PSC_EXT_CLOCK_C)))
                               || (!ch1_b_relocate_sel && ch2_phase_count);

  // ----------------------------------------------------------------------
  // P91: chip select 2, relocated ch2 A
  // ----------------------------------------------------------------------
  wire logic p91_cs       = expanded_mode_en && chip_select_2_en;
  wire logic p91_timer_out = ch2_a_relocate_sel && (ch2_compare_out || ch2_pwm1_out || ch2_pwm2_out);
  wire logic p91_drive    = p91_cs || p91_timer_out || pin91_direction_bit;

  assign pin91_out  = p91_cs        ? chip_select_2 :
                      p91_timer_out ? ch2_a_compare_out : port_nine_ctrl[P9_OUT91_BIT];
  assign pin91_oe_n = !p91_drive;

  assign ch2_a_capture_compare = pin91_in;
  assign ch2_a_capture_valid   = ch2_a_relocate_sel && ch2_capture_mode && ch2_ioa[3];
  assign ch2_b_output_allowed  = !(ch2_a_relocate_sel && ch2_pwm1_out);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  dir_write_oe_a: assert property (wr_en && hit_dir |=> port_a_oe_n == ~$past(pwdata[7:0]))
    else $error("port A enable does not follow direction write");
  data_write_out_a: assert property (wr_en && hit_data |=> port_a_out == $past(pwdata[7:0]))
    else $error("port A output does not follow data write");
  dir_read_hidden_a: assert property (psel && !pwrite && hit_dir |-> prdata == UNDEFINED_READ)
    else $error("direction register leaked on read");
  pin_state_mix_a: assert property (psel && !pwrite && hit_state |->
      prdata[7:0] == ((port_a_out & ~port_a_oe_n) | (port_a_in & port_a_oe_n)))
    else $error("pin state read wrong");
  strobe_drive_a: assert property (expanded_mode_en && low_write_strobe_en |->
      !pin90_oe_n && pin90_out == low_write_strobe)
    else $error("low strobe not driven on P90");
  ch2_capture_a: assert property (ch2_a_relocate_sel && ch2_ioa[3]
      && (ch2_mode == MODE_NORMAL || ch2_mode[3:2] == MODE_PHASE_TOP)
      |-> ch2_a_capture_valid && ch2_a_capture_compare == pin91_in)
    else $error("ch2 A capture path wrong");
  ch2_b_block_a: assert property (ch2_a_relocate_sel && ch2_mode == MODE_PWM1 && ch2_ioa[1:0] != 2'h0
      |-> !ch2_b_output_allowed)
    else $error("ch2 B output not suppressed");
  ch1_capture_a: assert property (ch1_b_relocate_sel && ch1_iob[3:2] == IO_INPUT_TOP
      && (ch1_mode == MODE_NORMAL || ch1_mode[3:2] == MODE_PHASE_TOP)
      |-> ch1_b_capture_valid && ch1_b_capture_compare == pin90_in)
    else $error("ch1 B capture path wrong");
  reloc_off_a: assert property (!ch1_b_relocate_sel |-> !ch1_b_capture_valid)
    else $error("ch1 B capture routed without relocation");
  ch1_drive_a: assert property (ch1_b_relocate_sel && !p90_strobe && ch1_mode == MODE_NORMAL
      && !ch1_iob[3] && ch1_iob[1:0] != 2'h0
      |-> !pin90_oe_n && pin90_out == ch1_b_compare_out)
    else $error("ch1 B compare not driven on P90");
  ro_write_err_a: assert property (psel && penable && pwrite && hit_state |-> pslverr)
    else $error("pin state write not refused");
  clock_c_a: assert property (ch1_b_relocate_sel && psc_ch2 == PSC_EXT_CLOCK_C |-> ext_clock_c_valid)
    else $error("clock C not selected");
  phase_clock_a: assert property (!ch1_b_relocate_sel && ch2_phase_count |-> ext_clock_c_valid)
    else $error("phase-count clock C not selected");
  gpio_default_a: assert property (!expanded_mode_en && alt_pin_select_reg == 2'h0 |->
      pin90_oe_n == !pin90_direction_bit && pin91_oe_n == !pin91_direction_bit)
    else $error("shared pin not general I/O");

  strobe_cover: cover property (p90_strobe && ch1_b_capture_valid);
  pwm1_cover: cover property (!ch2_b_output_allowed);
  clock_c_cover: cover property (ext_clock_c_valid ##1 wr_en && hit_psc);
  read_state_cover: cover property (psel && penable && !pwrite && hit_state);

endmodule // port_pin_function_select

`default_nettype wire

// >>> board_model.sv
`timescale 1ns/1ps
`default_nettype none

module board_model (
  input  wire logic       pclk,
  input  wire logic [7:0] port_a_out,
  input  wire logic [7:0] port_a_oe_n,
  output logic [7:0]      port_a_in,
  input  wire logic       pin90_out,
  input  wire logic       pin90_oe_n,
  output logic            pin90_in,
  input  wire logic       pin91_out,
  input  wire logic       pin91_oe_n,
  output logic            pin91_in,
  output logic            low_write_strobe,
  output logic            chip_select_2,
  output logic [2:0]      compare_out
);
  // ----------------------------------------
  // Far-side drivers
  // ----------------------------------------
  // Undriven pins see a pattern that shifts every cycle, so a stale value matches only by chance
  logic [15:0] pat = 16'hA5C3;
  always @(posedge pclk) pat <= {pat[14:0], pat[15] ^ pat[13]};
  assign port_a_in        = (port_a_out & ~port_a_oe_n) | (pat[7:0] & port_a_oe_n);
  assign pin90_in         = pin90_oe_n ? pat[8] : pin90_out;
  assign pin91_in         = pin91_oe_n ? pat[9] : pin91_out;
  assign low_write_strobe = pat[10];
  assign chip_select_2    = pat[11];
  assign compare_out      = pat[14:12];
endmodule // board_model

`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pin_select_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, a_in, a_out, a_oe_n;
  logic [31:0] pwdata = 32'h0, prdata, mdl [8];
  logic pready, pslverr, p90i, p90o, p90e, p91i, p91o, p91e, lws, cs2, b_ok;
  logic [2:0] cmp;
  logic c1v, c1d, c2v, c2d, ckv, ckd;
  logic [15:0] lf = 16'd43724;
  int err_count = 0, total_checks = 0, cyc = 0;
  logic [31:0] r, dv;
  logic e;
  logic [7:0] pv;

  always #4 pclk = ~pclk;

  port_pin_function_select port_pin_function_select_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .port_a_in(a_in), .port_a_out(a_out), .port_a_oe_n(a_oe_n), .pin90_in(p90i),
    .pin90_out(p90o), .pin90_oe_n(p90e), .pin91_in(p91i), .pin91_out(p91o), .pin91_oe_n(p91e),
    .low_write_strobe(lws), .chip_select_2(cs2), .ch1_b_compare_out(cmp[0]), .ch2_a_compare_out(cmp[1]),
    .ch2_b_compare_out(cmp[2]), .ch2_b_output_allowed(b_ok), .ch1_b_capture_compare(c1d),
    .ch1_b_capture_valid(c1v), .ch2_a_capture_compare(c2d), .ch2_a_capture_valid(c2v),
    .ext_clock_c_input(ckd), .ext_clock_c_valid(ckv));

  board_model board_model_inst (.pclk(pclk), .port_a_out(a_out), .port_a_oe_n(a_oe_n), .port_a_in(a_in),
    .pin90_out(p90o), .pin90_oe_n(p90e), .pin90_in(p90i), .pin91_out(p91o), .pin91_oe_n(p91e),
    .pin91_in(p91i), .low_write_strobe(lws), .chip_select_2(cs2), .compare_out(cmp));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic test_done;
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask

  // APB transfer: holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata; e = pslverr; pv = a_in;
    psel <= 1'b0; penable <= 1'b0;
    if (w && !e) mdl[a[4:2]] = d;
  endtask

  task automatic cfg(input logic [31:0] al, c1, c2, ps, p9);
    apb(1, ADDR_ALT_PIN_SELECT, al);
    apb(1, ADDR_CH1_TIMER_CFG, c1);
    apb(1, ADDR_CH2_TIMER_CFG, c2);
    apb(1, ADDR_PRESCALER_CFG, ps);
    apb(1, ADDR_PORT_NINE_CTRL, p9);
    @(negedge pclk);
  endtask

  initial begin
    for (int i = 0; i < 8; i++) mdl[i] = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("oe_n reset", 32'h0000_00FF, {24'h0, a_oe_n});
    apb(0, ADDR_PORT_A_OUTPUT_DATA, 32'h0);
    chk("data reset", 32'h0, r);
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      apb(1, ADDR_PORT_A_DIRECTION, {24'h0, lf[7:0]});
      lf = lfsr(lf);
      apb(1, ADDR_PORT_A_OUTPUT_DATA, {24'h0, lf[7:0]});
      apb(0, ADDR_PORT_A_DIRECTION, 32'h0);
      chk("dir read", UNDEFINED_READ, r);
      apb(0, ADDR_PORT_A_OUTPUT_DATA, 32'h0);
      chk("data read", mdl[1], r);
      apb(0, ADDR_PORT_A_PIN_STATE, 32'h0);
      dv = mdl[0];
      chk("pin state", {24'h0, (dv[7:0] & mdl[1][7:0]) | (~dv[7:0] & pv)}, r);
      @(negedge pclk);
      chk("oe_n", {24'h0, ~dv[7:0]}, {24'h0, a_oe_n});
      chk("out", mdl[1], {24'h0, a_out});
    end
    apb(0, 8'h24, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1, ADDR_PORT_A_PIN_STATE, 32'h0);
    chk("ro err", 32'h1, {31'h0, e});
    cfg(32'h1, 32'h0, 32'h80, 32'h0, 32'h0);
    chk("c2 valid", 32'h1, {31'h0, c2v});
    chk("c2 data", {31'h0, p91i}, {31'h0, c2d});
    cfg(32'h2, 32'h800, 32'h0, 32'h0, 32'h0);
    chk("c1 valid", 32'h1, {31'h0, c1v});
    chk("c1 data", {31'h0, p90i}, {31'h0, c1d});
    cfg(32'h0, 32'h800, 32'h0, 32'h0, 32'h0);
    chk("c1 off", 32'h0, {31'h0, c1v});
    cfg(32'h2, 32'h0, 32'h0, 32'h7, 32'h0);
    chk("clk ch0", 32'h1, {31'h0, ckv});
    chk("clk data", {31'h0, p90i}, {31'h0, ckd});
    cfg(32'h2, 32'h0, 32'h0, 32'h38, 32'h0);
    chk("clk ch2", 32'h1, {31'h0, ckv});
    cfg(32'h0, 32'h0, 32'h4, 32'h0, 32'h0);
    chk("clk phase", 32'h1, {31'h0, ckv});
    cfg(32'h1, 32'h0, 32'h12, 32'h0, 32'h0);
    chk("b gated", 32'h0, {31'h0, b_ok});
    cfg(32'h0, 32'h0, 32'h0, 32'h0, 32'h30);
    chk("lwr oe", 32'h0, {31'h0, p90e});
    chk("lwr out", {31'h0, lws}, {31'h0, p90o});
    cfg(32'h0, 32'h0, 32'h0, 32'h0, 32'h5);
    chk("p90 oe", 32'h0, {31'h0, p90e});
    chk("p90 out", 32'h1, {31'h0, p90o});
    chk("p91 oe", 32'h1, {31'h0, p91e});
    cfg(32'h2, 32'h100, 32'h0, 32'h0, 32'h0);
    chk("c1 cmp oe", 32'h0, {31'h0, p90e});
    chk("c1 cmp out", {31'h0, cmp[0]}, {31'h0, p90o});
    cfg(32'h0, 32'h100, 32'h0, 32'h0, 32'h0);
    chk("c1 cmp off", 32'h1, {31'h0, p90e});
    test_done();
  end
endmodule // tb

`default_nettype wire
